// ==== pkg/pps_params.svh ====
`ifndef PPS_PARAMS_SVH
`define PPS_PARAMS_SVH
// Register byte offsets on the AHB-Lite slave
`define PPS_OFF_PC_LOW_CFG   8'h00
`define PPS_OFF_PB_HIGH_CFG  8'h04
`define PPS_OFF_DEBUG_CFG    8'h08
`define PPS_OFF_EXT_INTERRUPT_C_SEL     8'h0C
`define PPS_OFF_EXT_INTERRUPT_D_SEL     8'h10
`define PPS_OFF_STATUS       8'h14
// Configuration nibble encodings
`define PPS_MODE_ANALOG      4'h0
`define PPS_MODE_ALT_OUT     4'h9
`define PPS_MODE_ALT_OD      4'hD
// Field positions inside the nibble-packed registers
`define PPS_PC1_LSB          4
`define PPS_PC0_LSB          0
`define PPS_PB7_LSB          12
`define PPS_PB6_LSB          8
`define PPS_PB5_LSB          4
`define PPS_DBG_GPIO_BIT     5
// Reset values
`define PPS_RST_NIBBLES      16'h4444
`define PPS_RST_DEBUG_CFG    8'h00
`define PPS_RST_EXT_INTERRUPT_C_SEL     5'h0F
`define PPS_RST_EXT_INTERRUPT_D_SEL     5'h10
// Number of digital pins selectable for external interrupts
`define PPS_NUM_GPIO         24
`define PPS_SEL_W            5
`endif

// ==== pkg/pps_pkg.sv ====
package pps_pkg;
  // Trace configuration from the core
  typedef struct packed {
    logic       enable;      // Trace interface on
    logic       async_mode;  // Asynchronous (serial wire output) form
    logic [2:0] sync_width;  // Synchronous width: 1, 2 or 4
  } pps_trace_t;
  // Per-pin drive bundle
  typedef struct packed {
    logic out;
    logic oe;
    logic pull_up;
  } pps_drive_t;
  // Debug protocol mode
  typedef enum logic [0:0] {
    PPS_JTAG = 1'b0,
    PPS_SWD  = 1'b1
  } pps_dbg_mode_t;
endpackage : pps_pkg

// ==== rtl/pps_sync.sv ====
`timescale 1ns/100ps
// Two flip-flop synchroniser for a pin bus
module pps_sync
  import pps_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;  // First stage, read only by second
  // Double register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : pps_sync

// ==== rtl/pps_irq_pick.sv ====
`timescale 1ns/100ps
`include "pps_params.svh"
// Registered selection of one pin out of the digital pin bus
module pps_irq_pick
  import pps_pkg::*;
(
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic [`PPS_NUM_GPIO-1:0]    pins,
  input  wire logic [`PPS_SEL_W-1:0]       sel,
  output logic                             irq
);
  // Pick the chosen pin; out-of-range picks read low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else if (sel < `PPS_SEL_W'(`PPS_NUM_GPIO)) begin
      irq <= pins[sel];
    end else begin
      irq <= 1'b0;
    end
  end
endmodule : pps_irq_pick

// ==== rtl/pps_pin_mux.sv ====
`timescale 1ns/100ps
`include "pps_params.svh"
module pps_pin_mux
  import pps_pkg::*;
(
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  // AHB-Lite slave
  input  wire logic                     hsel,
  input  wire logic [7:0]               haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic                     hready,
  input  wire logic [31:0]              hwdata,
  output logic      [31:0]              hrdata,
  output logic                          hreadyout,
  output logic                          hresp,
  // Core side
  input  wire pps_trace_t               trace_cfg,
  input  wire logic                     async_trace_out,
  input  wire logic                     sync_trace_bit0,
  input  wire logic                     sync_trace_bit1,
  input  wire logic                     swd_switch_seen,
  input  wire logic                     timer_a_ch1_oe,
  input  wire logic                     timer_a_ch2_oe,
  input  wire logic                     timer_a_channel1_out,
  input  wire logic                     timer_a_channel2_out,
  input  wire logic [4:0]               gpio_out,
  input  wire logic [4:0]               gpio_oe,
  input  wire logic [`PPS_NUM_GPIO-1:0] gpio_pins_in,
  // Pins (bit 4 C1, 3 C0, 2 B7, 1 B6, 0 B5)
  input  wire logic [4:0]               pin_in,
  output logic      [4:0]               pin_out,
  output logic      [4:0]               pin_oe,
  output logic      [4:0]               pin_pull_up,
  output logic      [4:0]               pin_analog,
  // Peripheral inputs
  output logic                          debug_reset_in,
  output logic                          ext_interrupt_b,
  output logic                          ext_interrupt_c,
  output logic                          ext_interrupt_d,
  output logic                          timer_a_channel1,
  output logic                          timer_a_channel2,
  output logic                          timer_b_ext_clock,
  output logic                          timer_a_clock_mask,
  output logic      [4:0]               gpio_in
);
  localparam int C1 = 4;  // Pin bus index of C1
  localparam int C0 = 3;  // Pin bus index of C0
  localparam int B7 = 2;  // Pin bus index of B7
  localparam int B6 = 1;  // Pin bus index of B6
  localparam int B5 = 0;  // Pin bus index of B5

  logic [15:0]            port_c_low_config_q;      // Nibbles for C1, C0
  logic [15:0]            port_b_high_config_q;     // Nibbles for B7..B5
  logic [7:0]             debug_pin_config_q;       // Debug pin release
  logic [`PPS_SEL_W-1:0]  interrupt_c_pin_select_q; // Pin index for C
  logic [`PPS_SEL_W-1:0]  interrupt_d_pin_select_q; // Pin index for D
  pps_dbg_mode_t          dbg_mode_q;               // Debug protocol
  logic [4:0]             pin_s;                    // Synchronised pins
  logic                   wr_pend_q;                // Write data phase
  logic [7:0]             wr_addr_q;                // Latched write offset
  logic                   c1_analog;
  logic                   c1_alt;
  logic                   c0_alt;
  logic                   b7_analog;
  logic                   b7_alt;
  logic                   b6_analog;
  logic                   b6_alt;
  logic                   b5_analog;
  logic                   c0_gpio;
  logic                   c0_debug_reset_in;
  logic                   sync_on;
  pps_drive_t             drv [5];                  // Next pin drive

  // Nibble equals a given mode
  function automatic logic nib_is(input logic [15:0] r, input int lsb,
                                  input logic [3:0] mode);
    nib_is = (r[lsb +: 4] == mode);
  endfunction : nib_is

  // Alternate output, push-pull or open-drain
  function automatic logic nib_alt(input logic [15:0] r, input int lsb);
    nib_alt = nib_is(r, lsb, `PPS_MODE_ALT_OUT) || nib_is(r, lsb, `PPS_MODE_ALT_OD);
  endfunction : nib_alt

  // Drive of an alternate output from its nibble and level
  function automatic pps_drive_t alt_drv(input logic [3:0] nib,
                                         input logic       v);
    // Open-drain only pulls low; a high level is left to the board
    if (nib == `PPS_MODE_ALT_OD) begin
      alt_drv = '{out: 1'b0, oe: !v, pull_up: 1'b0};
    end else begin
      alt_drv = '{out: v, oe: 1'b1, pull_up: 1'b0};
    end
  endfunction : alt_drv

  // Pin inputs pass two flip-flops
  pps_sync #(.W(5)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (pin_in),
    .q       (pin_s)
  );

  // Reselectable interrupt C and D sources
  pps_irq_pick u_irq_c (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pins    (gpio_pins_in),
    .sel     (interrupt_c_pin_select_q),
    .irq     (ext_interrupt_c)
  );
  pps_irq_pick u_irq_d (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pins    (gpio_pins_in),
    .sel     (interrupt_d_pin_select_q),
    .irq     (ext_interrupt_d)
  );

  // Debug mode: JTAG from reset, SWD once the debugger switches
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dbg_mode_q <= PPS_JTAG;
    end else if (swd_switch_seen) begin
      dbg_mode_q <= PPS_SWD;
    end
  end

  // AHB write address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else if (hready) begin
      wr_pend_q <= hsel && htrans[1] && hwrite;
      wr_addr_q <= haddr;
    end
  end

  // Register writes in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_c_low_config_q      <= `PPS_RST_NIBBLES;
      port_b_high_config_q     <= `PPS_RST_NIBBLES;
      debug_pin_config_q       <= `PPS_RST_DEBUG_CFG;
      interrupt_c_pin_select_q <= `PPS_RST_EXT_INTERRUPT_C_SEL;
      interrupt_d_pin_select_q <= `PPS_RST_EXT_INTERRUPT_D_SEL;
    end else if (wr_pend_q) begin
      case (wr_addr_q)
        `PPS_OFF_PC_LOW_CFG:  port_c_low_config_q      <= hwdata[15:0];
        `PPS_OFF_PB_HIGH_CFG: port_b_high_config_q     <= hwdata[15:0];
        `PPS_OFF_DEBUG_CFG:   debug_pin_config_q       <= hwdata[7:0];
        `PPS_OFF_EXT_INTERRUPT_C_SEL:    interrupt_c_pin_select_q <= hwdata[`PPS_SEL_W-1:0];
        `PPS_OFF_EXT_INTERRUPT_D_SEL:    interrupt_d_pin_select_q <= hwdata[`PPS_SEL_W-1:0];
        default: ; // Unmapped or read-only: ignored
      endcase
    end
  end

  // Read data registered at the address phase; zero when unmapped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr)
        `PPS_OFF_PC_LOW_CFG:  hrdata <= {16'h0000, port_c_low_config_q};
        `PPS_OFF_PB_HIGH_CFG: hrdata <= {16'h0000, port_b_high_config_q};
        `PPS_OFF_DEBUG_CFG:   hrdata <= {24'h000000, debug_pin_config_q};
        `PPS_OFF_EXT_INTERRUPT_C_SEL:    hrdata <= {27'h0, interrupt_c_pin_select_q};
        `PPS_OFF_EXT_INTERRUPT_D_SEL:    hrdata <= {27'h0, interrupt_d_pin_select_q};
        `PPS_OFF_STATUS:      hrdata <= {26'h0, dbg_mode_q, pin_s};
        default:              hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Decode of pin functions
  always_comb begin
    c1_analog = nib_is(port_c_low_config_q, `PPS_PC1_LSB, `PPS_MODE_ANALOG);
    c1_alt    = nib_alt(port_c_low_config_q, `PPS_PC1_LSB);
    c0_alt    = nib_alt(port_c_low_config_q, `PPS_PC0_LSB);
    b7_analog = nib_is(port_b_high_config_q, `PPS_PB7_LSB, `PPS_MODE_ANALOG);
    b7_alt    = nib_alt(port_b_high_config_q, `PPS_PB7_LSB);
    b6_analog = nib_is(port_b_high_config_q, `PPS_PB6_LSB, `PPS_MODE_ANALOG);
    b6_alt    = nib_alt(port_b_high_config_q, `PPS_PB6_LSB);
    b5_analog = nib_is(port_b_high_config_q, `PPS_PB5_LSB, `PPS_MODE_ANALOG);
    sync_on   = trace_cfg.enable && !trace_cfg.async_mode;
    // Trace bit 1 in use only for 2- or 4-wire trace
    c0_gpio   = debug_pin_config_q[`PPS_DBG_GPIO_BIT] ||
                (dbg_mode_q == PPS_SWD && !(sync_on && trace_cfg.sync_width >= 3'd2
                 && c0_alt));
    c0_debug_reset_in   = !c0_gpio && dbg_mode_q == PPS_JTAG &&
                !(sync_on && trace_cfg.sync_width >= 3'd2);
  end

  // Next drive of each pin
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      drv[i] = '{out: gpio_out[i], oe: gpio_oe[i], pull_up: 1'b0};
    end
    // C1: trace outputs or analog
    if (c1_analog) begin
      drv[C1] = '{out: 1'b0, oe: 1'b0, pull_up: 1'b0};
    end else if (c1_alt && trace_cfg.enable && trace_cfg.async_mode) begin
      drv[C1] = alt_drv(port_c_low_config_q[`PPS_PC1_LSB +: 4], async_trace_out);
    end else if (c1_alt && sync_on) begin
      drv[C1] = alt_drv(port_c_low_config_q[`PPS_PC1_LSB +: 4], sync_trace_bit0);
    end
    // C0: trace bit 1, JTAG reset, else GPIO
    if (!c0_gpio && c0_alt && sync_on && trace_cfg.sync_width >= 3'd2) begin
      drv[C0] = alt_drv(port_c_low_config_q[`PPS_PC0_LSB +: 4],
                        sync_trace_bit1);
    end else if (c0_debug_reset_in) begin
      drv[C0] = '{out: 1'b0, oe: 1'b0, pull_up: 1'b1};
    end else if (!c0_gpio) begin
      drv[C0] = '{out: 1'b0, oe: 1'b0, pull_up: 1'b0};
    end
    // B7 and B6: timer outputs or analog
    if (b7_analog) begin
      drv[B7] = '{out: 1'b0, oe: 1'b0, pull_up: 1'b0};
    end else if (b7_alt && timer_a_ch2_oe) begin
      drv[B7] = alt_drv(port_b_high_config_q[`PPS_PB7_LSB +: 4],
                        timer_a_channel2_out);
    end
    if (b6_analog) begin
      drv[B6] = '{out: 1'b0, oe: 1'b0, pull_up: 1'b0};
    end else if (b6_alt && timer_a_ch1_oe) begin
      drv[B6] = alt_drv(port_b_high_config_q[`PPS_PB6_LSB +: 4],
                        timer_a_channel1_out);
    end
    if (b5_analog) begin
      drv[B5] = '{out: 1'b0, oe: 1'b0, pull_up: 1'b0};
    end
  end

  // Registered pin drive
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out     <= 5'h00;
      pin_oe      <= 5'h00;
      pin_pull_up <= 5'h00;
      pin_analog  <= 5'h00;
    end else begin
      for (int i = 0; i < 5; i++) begin
        pin_out[i]     <= drv[i].out;
        pin_oe[i]      <= drv[i].oe;
        pin_pull_up[i] <= drv[i].pull_up;
      end
      pin_analog <= {c1_analog, 1'b0, b7_analog, b6_analog, b5_analog};
    end
  end

  // Registered peripheral inputs from synchronised pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      debug_reset_in     <= 1'b1;
      ext_interrupt_b    <= 1'b0;
      timer_a_channel1   <= 1'b0;
      timer_a_channel2   <= 1'b0;
      timer_b_ext_clock  <= 1'b0;
      timer_a_clock_mask <= 1'b0;
      gpio_in            <= 5'h00;
    end else begin
      debug_reset_in     <= c0_debug_reset_in ? pin_s[C0] : 1'b1;
      ext_interrupt_b    <= pin_s[B6];
      timer_a_channel1   <= pin_s[B6];
      timer_a_channel2   <= pin_s[B7];
      timer_b_ext_clock  <= pin_s[B5];
      timer_a_clock_mask <= pin_s[B5];
      gpio_in            <= pin_s;
    end
  end
endmodule : pps_pin_mux

// ==== testbench/pps_board_model.sv ====
`timescale 1ns/100ps
// Board and debugger around the shared pins
module pps_board_model #(
  parameter int DLY = 2  // Cycles the debugger spends on the switch sequence
) (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [4:0] pin_out,
  input  wire logic [4:0] pin_oe,
  input  wire logic [4:0] pin_pull_up,
  input  wire logic [4:0] drv_en,
  input  wire logic [4:0] drv_val,
  input  wire logic       do_switch,
  output logic      [4:0] pin_in,
  output logic            swd_switch_seen
);
  logic       tog_q;  // Wander pattern of an unheld pin
  logic [7:0] sw_q;   // Switch sequence in flight
  // Unheld, unpulled pins change every cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) tog_q <= 1'b0;
    else tog_q <= ~tog_q;
  end
  // Debugger sends the switch sequence, done DLY+1 cycles later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) sw_q <= 8'h00;
    else sw_q <= {sw_q[6:0], do_switch};
  end
  assign swd_switch_seen = sw_q[DLY];
  // Wire level: device, then board, then pull-up, else wander
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (drv_en[i]) pin_in[i] = drv_val[i];
      else if (pin_pull_up[i]) pin_in[i] = 1'b1;
      else pin_in[i] = tog_q ^ i[0];
    end
  end
endmodule : pps_board_model

// ==== testbench/pps_pin_mux_chk.sv ====
`timescale 1ns/100ps
`include "pps_params.svh"
// Port-level watch on the pin mux
module pps_pin_mux_chk
  import pps_pkg::*;
(
  input wire logic                     hclk,
  input wire logic                     hresetn,
  input wire pps_trace_t               trace_cfg,
  input wire logic                     swd_switch_seen,
  input wire logic                     timer_a_ch1_oe,
  input wire logic                     timer_a_ch2_oe,
  input wire logic [4:0]               gpio_oe,
  input wire logic [`PPS_NUM_GPIO-1:0] gpio_pins_in,
  input wire logic [4:0]               pin_in,
  input wire logic [4:0]               pin_oe,
  input wire logic [4:0]               gpio_in,
  input wire logic                     debug_reset_in,
  input wire logic                     ext_interrupt_b,
  input wire logic                     ext_interrupt_c,
  input wire logic                     ext_interrupt_d,
  input wire logic                     timer_a_channel1,
  input wire logic                     timer_a_channel2,
  input wire logic                     timer_b_ext_clock,
  input wire logic                     timer_a_clock_mask
);
  logic [1:0] up_q;   // Edges since reset release, saturating
  logic       swd_q;  // Switch sequence has been seen
  // Count edges so the 3-edge input path is filled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  // Remember the mode switch until reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) swd_q <= 1'b0;
    else swd_q <= swd_q | swd_switch_seen;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_filled; up_q == 2'h3; endsequence
  sequence s_swd; swd_q ##1 swd_q; endsequence
  chk_ext_interrupt_b_pin: assert property (s_filled |-> ext_interrupt_b == $past(pin_in[1], 3))
    else $error("irq b not following pin b6");
  chk_cap_fixed: assert property (s_filled |->
    timer_a_channel1 == $past(pin_in[1], 3) && timer_a_channel2 == $past(pin_in[2], 3))
    else $error("timer captures not on b6 b7");
  chk_b5_clock: assert property (s_filled |->
    timer_b_ext_clock == $past(pin_in[0], 3) && timer_a_clock_mask == timer_b_ext_clock)
    else $error("b5 clock inputs wrong");
  chk_gpio_in: assert property (s_filled |-> gpio_in == $past(pin_in, 3))
    else $error("gpio input path wrong");
  chk_c1_quiet: assert property (!trace_cfg.enable && !gpio_oe[4] |=> !pin_oe[4])
    else $error("c1 driven without trace or gpio");
  chk_b6_quiet: assert property (!timer_a_ch1_oe && !gpio_oe[1] |=> !pin_oe[1])
    else $error("b6 driven without enable");
  chk_b7_quiet: assert property (!timer_a_ch2_oe && !gpio_oe[2] |=> !pin_oe[2])
    else $error("b7 driven without enable");
  chk_irq_idle: assert property (gpio_pins_in == '0 |=> !ext_interrupt_c && !ext_interrupt_d)
    else $error("irq c d high with all pins low");
  chk_swd_debug_reset_in: assert property (s_swd |-> ##1 debug_reset_in)
    else $error("jtag reset active in serial wire mode");
endmodule : pps_pin_mux_chk
bind pps_pin_mux pps_pin_mux_chk u_chk (.hclk, .hresetn, .trace_cfg, .swd_switch_seen,
  .timer_a_ch1_oe, .timer_a_ch2_oe, .gpio_oe, .gpio_pins_in, .pin_in, .pin_oe, .gpio_in,
  .debug_reset_in, .ext_interrupt_b, .ext_interrupt_c, .ext_interrupt_d, .timer_a_channel1,
  .timer_a_channel2, .timer_b_ext_clock, .timer_a_clock_mask);

// ==== testbench/pps_pin_mux_tb.sv ====
`timescale 1ns/100ps
`include "pps_params.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module pps_pin_mux_tb
  import pps_pkg::*;
;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, r;
  logic        hreadyout, hresp, swd_switch_seen, do_switch = 1'b0;
  pps_trace_t  trace_cfg = '0;
  logic        async_trace_out = 1'b0, sync_trace_bit0 = 1'b0, sync_trace_bit1 = 1'b0;
  logic        timer_a_ch1_oe = 1'b0, timer_a_ch2_oe = 1'b0;
  logic        timer_a_channel1_out = 1'b0, timer_a_channel2_out = 1'b0;
  logic [4:0]  gpio_out = 5'h00, gpio_oe = 5'h00, drv_en = 5'h00, drv_val = 5'h00;
  logic [4:0]  pin_in, pin_out, pin_oe, pin_pull_up, pin_analog, gpio_in;
  logic [`PPS_NUM_GPIO-1:0] gpio_pins_in = '0;
  logic        debug_reset_in, ext_interrupt_b, ext_interrupt_c, ext_interrupt_d;
  logic        timer_a_channel1, timer_a_channel2, timer_b_ext_clock, timer_a_clock_mask;
  int          err_count = 0, compares = 0;
  pps_pin_mux u_pps_pin_mux (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .trace_cfg, .async_trace_out,
    .sync_trace_bit0, .sync_trace_bit1, .swd_switch_seen, .timer_a_ch1_oe, .timer_a_ch2_oe,
    .timer_a_channel1_out, .timer_a_channel2_out, .gpio_out, .gpio_oe, .gpio_pins_in,
    .pin_in, .pin_out, .pin_oe, .pin_pull_up, .pin_analog, .debug_reset_in,
    .ext_interrupt_b, .ext_interrupt_c, .ext_interrupt_d, .timer_a_channel1,
    .timer_a_channel2, .timer_b_ext_clock, .timer_a_clock_mask, .gpio_in);
  pps_board_model u_pps_board_model (.hclk, .hresetn, .pin_out, .pin_oe, .pin_pull_up,
    .drv_en, .drv_val, .do_switch, .pin_in, .swd_switch_seen);
  // Clock at 200 MHz
  always #2.5 hclk = ~hclk;
  // Verdict and end of run
  task automatic final_report();
    if (err_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  // Bounded wait for hready
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 16);
    if (hreadyout !== 1'b1) begin
      err_count++;
      final_report();
    end
  endtask : wait_rdy
  // One single word transfer, read data left in r
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask : ahb
  // Read and compare one register
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    `CHK(n, e, r)
  endtask : rd_chk
  // Let config and pin paths settle
  task automatic settle();
    repeat (5) @(posedge hclk);
  endtask : settle
  // Reset values, GPIO ownership, JTAG reset on C0
  task automatic t_reset();
    rd_chk("pc_cfg", `PPS_OFF_PC_LOW_CFG, 32'h0000_4444);
    rd_chk("pb_cfg", `PPS_OFF_PB_HIGH_CFG, 32'h0000_4444);
    rd_chk("ext_interrupt_c_sel", `PPS_OFF_EXT_INTERRUPT_C_SEL, 32'h0000_000F);
    rd_chk("ext_interrupt_d_sel", `PPS_OFF_EXT_INTERRUPT_D_SEL, 32'h0000_0010);
    ahb(1'b1, 8'h18, 32'hFFFF_FFFF);
    rd_chk("unmapped", 8'h18, 32'h0000_0000);
    @(posedge hclk);
    gpio_oe <= 5'h1F;
    gpio_out <= 5'h0A;
    drv_en <= 5'h08;
    settle();
    `CHK("gpio_oe", 5'h17, pin_oe)
    `CHK("gpio_out", 5'h02, pin_out & 5'h17)
    `CHK("debug_reset_in_low", 2'b10, {pin_pull_up[3], debug_reset_in})
    @(posedge hclk);
    drv_en <= 5'h00;
    settle();
    `CHK("debug_reset_in_pull", 1'b1, debug_reset_in)
  endtask : t_reset
  // Analog nibbles on C1, B7, B6, B5
  task automatic t_analog();
    ahb(1'b1, `PPS_OFF_PC_LOW_CFG, 32'h0000_0004);
    ahb(1'b1, `PPS_OFF_PB_HIGH_CFG, 32'h0000_0004);
    settle();
    `CHK("analog", 5'h17, pin_analog)
    `CHK("analog_oe", 5'h00, pin_oe & 5'h17)
  endtask : t_analog
  // Trace forms on C1 and C0
  task automatic t_trace();
    ahb(1'b1, `PPS_OFF_PC_LOW_CFG, 32'h0000_0099);
    @(posedge hclk);
    trace_cfg <= '{enable: 1'b1, async_mode: 1'b1, sync_width: 3'h0};
    async_trace_out <= 1'b1;
    settle();
    `CHK("c1_async", 2'b11, {pin_out[4], pin_oe[4]})
    `CHK("c0_debug_reset_in", 2'b01, {pin_oe[3], pin_pull_up[3]})
    @(posedge hclk);
    trace_cfg <= '{enable: 1'b1, async_mode: 1'b0, sync_width: 3'h4};
    async_trace_out <= 1'b0;
    sync_trace_bit0 <= 1'b1;
    sync_trace_bit1 <= 1'b1;
    settle();
    `CHK("sync4", 4'hF, {pin_out[4:3], pin_oe[4:3]})
    @(posedge hclk);
    trace_cfg.sync_width <= 3'h1;
    settle();
    `CHK("sync1", 3'b101, {pin_oe[4:3], pin_pull_up[3]})
    @(posedge hclk);
    trace_cfg <= '0;
  endtask : t_trace
  // Timer outputs and fixed inputs on B7, B6, B5
  task automatic t_timer();
    ahb(1'b1, `PPS_OFF_PB_HIGH_CFG, 32'h0000_D944);
    @(posedge hclk);
    gpio_oe <= 5'h00;
    timer_a_ch1_oe <= 1'b1;
    timer_a_ch2_oe <= 1'b1;
    timer_a_channel1_out <= 1'b1;
    settle();
    `CHK("tmr_out", 4'h7, {pin_out[2:1], pin_oe[2:1]})
    @(posedge hclk);
    timer_a_channel2_out <= 1'b1;
    settle();
    `CHK("tmr_od", 2'b01, pin_oe[2:1])
    @(posedge hclk);
    timer_a_ch1_oe <= 1'b0;
    timer_a_ch2_oe <= 1'b0;
    drv_en <= 5'h07;
    drv_val <= 5'h03;
    settle();
    `CHK("tmr_in_a", 5'h0F, {timer_a_channel2, timer_a_channel1, ext_interrupt_b,
      timer_b_ext_clock, timer_a_clock_mask})
    @(posedge hclk);
    drv_val <= 5'h04;
    settle();
    `CHK("tmr_in_b", 5'h10, {timer_a_channel2, timer_a_channel1, ext_interrupt_b,
      timer_b_ext_clock, timer_a_clock_mask})
  endtask : t_timer
  // Interrupt C and D pin selection
  task automatic t_irq();
    @(posedge hclk);
    gpio_pins_in <= 24'h00_8000;
    settle();
    `CHK("irq_dflt_c", 2'b10, {ext_interrupt_c, ext_interrupt_d})
    gpio_pins_in <= 24'h01_0000;
    settle();
    `CHK("irq_dflt_d", 2'b01, {ext_interrupt_c, ext_interrupt_d})
    ahb(1'b1, `PPS_OFF_EXT_INTERRUPT_C_SEL, 32'h0000_0003);
    ahb(1'b1, `PPS_OFF_EXT_INTERRUPT_D_SEL, 32'h0000_0017);
    gpio_pins_in <= 24'h80_0008;
    settle();
    `CHK("irq_sel_on", 2'b11, {ext_interrupt_c, ext_interrupt_d})
    gpio_pins_in <= 24'h01_8000;
    settle();
    `CHK("irq_sel_off", 2'b00, {ext_interrupt_c, ext_interrupt_d})
  endtask : t_irq
  // C0 release, mode switch, trace bit 1, reset back to JTAG
  task automatic t_swd();
    ahb(1'b1, `PPS_OFF_DEBUG_CFG, 32'h0000_0020);
    gpio_oe <= 5'h08;
    gpio_out <= 5'h08;
    drv_en <= 5'h00;
    settle();
    `CHK("c0_free", 3'b111, {pin_out[3], pin_oe[3], debug_reset_in})
    ahb(1'b1, `PPS_OFF_DEBUG_CFG, 32'h0000_0000);
    settle();
    `CHK("c0_jtag", 2'b01, {pin_oe[3], pin_pull_up[3]})
    do_switch <= 1'b1;
    @(posedge hclk);
    do_switch <= 1'b0;
    settle();
    ahb(1'b0, `PPS_OFF_STATUS, 32'h0);
    `CHK("swd_mode", 1'b1, r[5])
    `CHK("c0_swd", 2'b11, {pin_oe[3], debug_reset_in})
    trace_cfg <= '{enable: 1'b1, async_mode: 1'b0, sync_width: 3'h2};
    sync_trace_bit1 <= 1'b0;
    settle();
    `CHK("c0_trace", 2'b01, {pin_out[3], pin_oe[3]})
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, `PPS_OFF_STATUS, 32'h0);
    `CHK("jtag_again", 1'b0, r[5])
  endtask : t_swd
  // Main sequence
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_analog();
    t_trace();
    t_timer();
    t_irq();
    t_swd();
    final_report();
  end
endmodule : pps_pin_mux_tb
